//--- logic/e1_rx_params.svh
// constants for the receive options register and receive-path timing
`ifndef E1_RX_PARAMS_SVH
`define E1_RX_PARAMS_SVH

// register map, normal-mode page
`define RXOPT_OFFSET 7'h00
`define RXOPT_RESET 8'h00
`define NORMAL_SEL_BIT 7

// field positions in the receive options register
`define FASW_BIT 7
`define CNTNA_BIT 6
`define BYPASS_BIT 5
`define TXSLIP_BIT 4
`define RAWPCM_BIT 3
`define SIGMF_BIT 2
`define CRCMF_BIT 1
`define TRUNK_BIT 0

// frame structure
`define FRAME_BITS 256
`define MF_FRAMES 16
`define FAS_PATTERN 7'h1b
`define NFAS_BIT_IDX 8'h01
`define FAS_LAST_IDX 8'h07

`endif

//--- logic/e1_rx_pkg.sv
// types shared by the receive options block
package e1_rx_pkg;

  // field order matches register bits 7 down to 0
  typedef struct packed {
    logic fasWordErrorMode;
    logic countNonalignBitErrors;
    logic slipBufferBypass;
    logic transmitSlipMeasure;
    logic rawPcmSelect;
    logic rxSigMultiframePulseSel;
    logic rxCrcMultiframePulseSel;
    logic trunkConditionEnable;
  } rx_options_t;

  // signals arriving from the line side, all outside the sys_clk domain
  typedef struct packed {
    logic recoveredLineClock;
    logic undecodedRxPcm;
    logic decodedRxPcm;
    logic linePosPulse;
    logic lineNegPulse;
    logic slipBufferPcm;
    logic frameMark;
    logic crcMfMark;
    logic sigMfMark;
    logic outOfFrame;
  } line_in_t;

  // frame pulse encoding, {sig select, crc select}
  typedef enum logic [1:0] {
    FP_FRAME = 2'h0,
    FP_CRC = 2'h1,
    FP_COMPOSITE = 2'h3,
    FP_SIG = 2'h2
  } fp_mode_t;

endpackage

//--- logic/sync_bits.sv
// two-flop synchroniser, one pair per bit
`timescale 1ns/1ns
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1_reg;
      logic stage2_reg;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else if (ce) begin
          stage1_reg <= din[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign dout[i] = stage2_reg;
    end
  endgenerate

endmodule

//--- logic/e1_receive_options_ctrl.sv
// receive options register and the receive-path behaviour it selects
`timescale 1ns/1ns
`include "e1_rx_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [R1] unused bit writes do nothing; software masks unused bits on read
// [R2] every writable bit reads back its last written value
// [R3] reset clears all option bits to zero
// [R4] writes to read-only bits leave operation unaffected
// [R5] eight read/write option bits at offset zero, bit 7 down to 0
// [R6] word mode counts one per errored FAS word, else one per bit
// [R7] nonalign counting adds a count for zero in TS0 bit 2 of NFAS
// [R8] both set: eight-bit word of FAS plus next NFAS bit 2, counted once
// [R9] nonalign counting off: only FAS word errors count
// [R10] slip buffer bypass routes received data straight to backplane output
// [R11] transmit slip measure clocks slip buffer system side from transmit clock
// [R12] software sets transmit slip measure only with bypass set
// [R13] raw select gives undecoded PCM, otherwise decoded PCM
// [R14] no multiframe select: one-bit pulse at bit 1 of every frame
// [R15] crc select: pulse at bit 1 of frame 1 of every 16 frames
// [R16] signalling select: pulse at bit 1 of frame 1 every 16 frames
// [R17] both: rise at signalling MF start, fall after CRC MF bit 1
// [R18] trunk enable with out-of-frame puts idle code in every timeslot
// [R19] trunk conditioning only when dual rail and bypass both off
// [R20] per-timeslot conditioning from signalling extractor still available
// [R21] dual rail select turns backplane outputs into line pulse rails
// [R22] idle code comes from the slip buffer idle code register
// [R23] address bit 7 low selects normal registers
// [R24] option bits retimed into the receive bit timing before use
////////////////////////////////////////////////////////////////////////////////
module e1_receive_options_ctrl
  import e1_rx_pkg::*;
#(
  parameter int FRAME_BITS = `FRAME_BITS,
  parameter int MF_FRAMES = `MF_FRAMES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic regSelect,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic recoveredLineClock,
  input wire logic undecodedRxPcm,
  input wire logic decodedRxPcm,
  input wire logic linePosPulse,
  input wire logic lineNegPulse,
  input wire logic slipBufferPcm,
  input wire logic frameMark,
  input wire logic crcMfMark,
  input wire logic sigMfMark,
  input wire logic outOfFrame,
  input wire logic backplaneDualRailSel,
  input wire logic [7:0] slipBufferIdleCode,
  input wire logic sigxCondActive,
  input wire logic sigxCondData,
  input wire logic backplaneSigIn,
  output logic rxPcm,
  output logic rxFramePulse,
  output logic backplaneRxPcm,
  output logic backplaneNegRail,
  output logic framingErrPulse,
  output logic slipBypassRoute,
  output logic slipSysClkFromTx
);

  localparam int BW = $clog2(FRAME_BITS);
  localparam int FW = $clog2(MF_FRAMES);
  // a literal cannot be bit-selected, so the pattern lives in a named constant
  localparam logic [6:0] FAS_WORD = `FAS_PATTERN;

  ////////////////////////////////////////////////////////////////////////////
  // line-side inputs: two flops, then edge detect on the recovered clock
  line_in_t lineRaw;
  line_in_t lineSync;
  logic [$bits(line_in_t)-1:0] lineSyncBits;
  logic lineClkPrev_reg;
  wire riseEdge;
  wire fallEdge;

  assign lineRaw = '{recoveredLineClock: recoveredLineClock,
                     undecodedRxPcm: undecodedRxPcm,
                     decodedRxPcm: decodedRxPcm,
                     linePosPulse: linePosPulse,
                     lineNegPulse: lineNegPulse,
                     slipBufferPcm: slipBufferPcm,
                     frameMark: frameMark,
                     crcMfMark: crcMfMark,
                     sigMfMark: sigMfMark,
                     outOfFrame: outOfFrame};

  sync_bits #(
    .WIDTH($bits(line_in_t))
  ) u_line_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .din(lineRaw),
    .dout(lineSyncBits)
  );

  assign lineSync = line_in_t'(lineSyncBits);
  assign riseEdge = ce & lineSync.recoveredLineClock & ~lineClkPrev_reg;
  assign fallEdge = ce & ~lineSync.recoveredLineClock & lineClkPrev_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lineClkPrev_reg <= 1'b0;
    end else if (ce) begin
      lineClkPrev_reg <= lineSync.recoveredLineClock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // processor access: only bit 7 low reaches this page
  rx_options_t opt_reg;
  rx_options_t optLine_reg;
  logic [7:0] rdData_reg;
  wire normalSel;
  wire optHit;
  wire wrHit;
  wire rdHit;

  assign normalSel = regSelect & ~regAddr[`NORMAL_SEL_BIT]; // R23
  assign optHit = normalSel & (regAddr[6:0] == `RXOPT_OFFSET);
  assign wrHit = optHit & regWrite;
  assign rdHit = normalSel & regRead;

  // all eight bits are defined, so nothing is read-only or unused here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt_reg <= rx_options_t'(`RXOPT_RESET); // R3
    end else if (ce && wrHit) begin
      opt_reg <= rx_options_t'(regWrData); // R1 R4 R5
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else if (ce && rdHit) begin
      rdData_reg <= optHit ? opt_reg : 8'h00; // R2
    end
  end

  assign regRdData = rdData_reg;

  // options change only on the rising line edge, mid-bit, never at a bit boundary
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      optLine_reg <= rx_options_t'(`RXOPT_RESET);
    end else if (riseEdge) begin
      optLine_reg <= opt_reg; // R24
    end
  end

  assign slipBypassRoute = optLine_reg.slipBufferBypass; // R10
  assign slipSysClkFromTx = optLine_reg.transmitSlipMeasure; // R11 R12

  ////////////////////////////////////////////////////////////////////////////
  // bit, CRC and signalling frame counters; free-run when marks stop
  logic [BW-1:0] bitCnt_reg;
  logic [BW-1:0] bitCnt_next;
  logic [FW-1:0] crcFrm_reg;
  logic [FW-1:0] crcFrm_next;
  logic [FW-1:0] sigFrm_reg;
  logic [FW-1:0] sigFrm_next;

  always_comb begin
    bitCnt_next = bitCnt_reg;
    crcFrm_next = crcFrm_reg;
    sigFrm_next = sigFrm_reg;
    if (fallEdge) begin
      bitCnt_next = bitCnt_reg + BW'(1);
      if (bitCnt_reg == BW'(FRAME_BITS - 1)) begin
        crcFrm_next = crcFrm_reg + FW'(1);
        sigFrm_next = sigFrm_reg + FW'(1);
      end
    end else if (riseEdge) begin
      if (lineSync.frameMark) begin
        bitCnt_next = '0;
      end
      if (lineSync.crcMfMark) begin
        crcFrm_next = '0;
      end
      if (lineSync.sigMfMark) begin
        sigFrm_next = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bitCnt_reg <= '0;
      crcFrm_reg <= '0;
      sigFrm_reg <= '0;
    end else begin
      bitCnt_reg <= bitCnt_next;
      crcFrm_reg <= crcFrm_next;
      sigFrm_reg <= sigFrm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame pulse, changed on the falling line edge that starts a bit
  fp_mode_t fpMode;
  fp_mode_t fpModeUsed_reg;
  logic fp_reg;
  logic fp_next;
  logic crcBit1_reg;
  wire newBit1;
  wire crcStart;
  wire sigStart;

  assign fpMode = fp_mode_t'({optLine_reg.rxSigMultiframePulseSel,
                              optLine_reg.rxCrcMultiframePulseSel});
  assign newBit1 = (bitCnt_next == '0);
  assign crcStart = newBit1 & (crcFrm_next == '0);
  assign sigStart = newBit1 & (sigFrm_next == '0);

  always_comb begin
    unique case (fpMode)
      FP_FRAME: fp_next = newBit1; // R14
      FP_CRC: fp_next = crcStart; // R15
      FP_SIG: fp_next = sigStart; // R16
      FP_COMPOSITE: fp_next = sigStart | (fp_reg & ~crcBit1_reg); // R17
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fp_reg <= 1'b0;
      crcBit1_reg <= 1'b0;
      fpModeUsed_reg <= FP_FRAME;
    end else if (fallEdge) begin
      fp_reg <= fp_next;
      crcBit1_reg <= crcStart;
      fpModeUsed_reg <= fpMode;
    end
  end

  assign rxFramePulse = fp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // framing error counting, sampled on the rising line edge
  logic rxBit;
  logic [2:0] patIdx;
  logic wordAcc_reg;
  logic wordPend_reg;
  logic errPulse_reg;
  logic errInc;
  wire fasFrame;
  wire inFasWord;
  wire lastFas;
  wire nfasCheck;
  wire bitErr;
  wire nfasErr;
  wire fas_word_error_mode;

  assign rxBit = lineSync.decodedRxPcm;
  assign patIdx = 3'(3'h7 - bitCnt_reg[2:0]);
  assign fasFrame = ~crcFrm_reg[0];
  assign inFasWord = fasFrame & (bitCnt_reg >= BW'(1)) & (bitCnt_reg <= BW'(`FAS_LAST_IDX));
  assign lastFas = fasFrame & (bitCnt_reg == BW'(`FAS_LAST_IDX));
  assign nfasCheck = ~fasFrame & (bitCnt_reg == BW'(`NFAS_BIT_IDX));
  assign bitErr = inFasWord & (rxBit != FAS_WORD[patIdx]);
  assign nfasErr = nfasCheck & ~rxBit;
  assign fas_word_error_mode = wordAcc_reg | bitErr;

  always_comb begin
    errInc = 1'b0;
    if (optLine_reg.fasWordErrorMode && optLine_reg.countNonalignBitErrors) begin
      errInc = nfasCheck & (wordPend_reg | nfasErr); // R8
    end else if (optLine_reg.fasWordErrorMode) begin
      errInc = lastFas & fas_word_error_mode; // R6 R9
    end else begin
      errInc = bitErr | (optLine_reg.countNonalignBitErrors & nfasErr); // R6 R7 R9
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wordAcc_reg <= 1'b0;
      wordPend_reg <= 1'b0;
      errPulse_reg <= 1'b0;
    end else if (ce) begin
      errPulse_reg <= riseEdge & errInc;
      if (riseEdge) begin
        wordAcc_reg <= lastFas ? 1'b0 : fas_word_error_mode;
        if (lastFas) begin
          wordPend_reg <= fas_word_error_mode;
        end else if (nfasCheck) begin
          wordPend_reg <= 1'b0;
        end
      end
    end
  end

  assign framingErrPulse = errPulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receive PCM and backplane outputs
  logic rxPcm_reg;
  logic bpPcm_reg;
  logic bpNeg_reg;
  logic bpPcm_next;
  wire trunkActive;
  wire idleBit;
  wire pcmSrc;

  // idle code is serialised on receive timing; slip buffer side not modelled
  assign idleBit = slipBufferIdleCode[patIdx]; // R22
  assign trunkActive = optLine_reg.trunkConditionEnable & lineSync.outOfFrame &
                       ~backplaneDualRailSel & ~optLine_reg.slipBufferBypass; // R19
  assign pcmSrc = optLine_reg.slipBufferBypass ? lineSync.decodedRxPcm
                                               : lineSync.slipBufferPcm; // R10

  always_comb begin
    if (backplaneDualRailSel) begin
      bpPcm_next = lineSync.linePosPulse; // R21
    end else if (trunkActive) begin
      bpPcm_next = idleBit; // R18
    end else if (sigxCondActive) begin
      bpPcm_next = sigxCondData; // R20
    end else begin
      bpPcm_next = pcmSrc;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxPcm_reg <= 1'b0;
      bpPcm_reg <= 1'b0;
      bpNeg_reg <= 1'b0;
    end else if (ce) begin
      rxPcm_reg <= optLine_reg.rawPcmSelect ? lineSync.undecodedRxPcm
                                            : lineSync.decodedRxPcm; // R13
      bpPcm_reg <= bpPcm_next;
      bpNeg_reg <= backplaneDualRailSel ? lineSync.lineNegPulse : backplaneSigIn; // R21
    end
  end

  assign rxPcm = rxPcm_reg;
  assign backplaneRxPcm = bpPcm_reg;
  assign backplaneNegRail = bpNeg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_clear;
    $past(rst) |-> (opt_reg == 8'h00) && (optLine_reg == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("options not clear after reset"); // R3

  property p_readback;
    (ce && wrHit) ##1 !(ce && wrHit) ##1 (ce && rdHit && optHit && !wrHit) |=>
      regRdData == $past(regWrData, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("read value differs from write"); // R2

  property p_field_map;
    (ce && wrHit) |=> opt_reg.fasWordErrorMode == $past(regWrData[`FASW_BIT]) &&
      opt_reg.trunkConditionEnable == $past(regWrData[`TRUNK_BIT]) &&
      opt_reg.slipBufferBypass == $past(regWrData[`BYPASS_BIT]);
  endproperty
  a_field_map: assert property (p_field_map) else $error("option field misplaced"); // R5

  property p_word_count;
    (framingErrPulse && $past(optLine_reg.fasWordErrorMode) &&
     !$past(optLine_reg.countNonalignBitErrors)) |->
      $past(bitCnt_reg) == BW'(`FAS_LAST_IDX) && !$past(crcFrm_reg[0]);
  endproperty
  a_word_count: assert property (p_word_count) else $error("word error counted off word end"); // R6

  property p_raw_pcm;
    (ce && optLine_reg.rawPcmSelect) ##1 (ce && optLine_reg.rawPcmSelect) |->
      rxPcm == $past(lineSync.undecodedRxPcm);
  endproperty
  a_raw_pcm: assert property (p_raw_pcm) else $error("raw PCM not selected"); // R13

  property p_frame_pulse;
    (rxFramePulse && fpModeUsed_reg == FP_FRAME) |-> bitCnt_reg == '0;
  endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse off bit 1"); // R14

  property p_crc_pulse;
    (rxFramePulse && fpModeUsed_reg == FP_CRC) |-> bitCnt_reg == '0 && crcFrm_reg == '0;
  endproperty
  a_crc_pulse: assert property (p_crc_pulse) else $error("CRC pulse off frame 1"); // R15

  property p_sig_pulse;
    (rxFramePulse && fpModeUsed_reg == FP_SIG) |-> bitCnt_reg == '0 && sigFrm_reg == '0;
  endproperty
  a_sig_pulse: assert property (p_sig_pulse) else $error("signalling pulse off frame 1"); // R16

  property p_composite_rise;
    ($rose(rxFramePulse) && fpModeUsed_reg == FP_COMPOSITE) |->
      bitCnt_reg == '0 && sigFrm_reg == '0;
  endproperty
  a_composite_rise: assert property (p_composite_rise) else $error("composite rise misplaced"); // R17

  property p_trunk_idle;
    (ce && trunkActive) |=> backplaneRxPcm == $past(idleBit);
  endproperty
  a_trunk_idle: assert property (p_trunk_idle) else $error("idle code not inserted"); // R18

  property p_bypass_route;
    (ce && optLine_reg.slipBufferBypass && !backplaneDualRailSel && !sigxCondActive) |=>
      backplaneRxPcm == $past(lineSync.decodedRxPcm);
  endproperty
  a_bypass_route: assert property (p_bypass_route) else $error("bypass not routed"); // R10 R19

  c_composite: cover property ($fell(rxFramePulse) && fpModeUsed_reg == FP_COMPOSITE);
  c_trunk: cover property (trunkActive);
  c_word_err: cover property (framingErrPulse && optLine_reg.fasWordErrorMode);

endmodule

//--- verif/e1_line_model.sv
// line-side model: recovered clock, framed data with marks and fault injection
`timescale 1ns/1ns
`include "e1_rx_params.svh"
module e1_line_model
  import e1_rx_pkg::*;
#(
  parameter int FRAME_BITS = 32,
  parameter int SIG_OFS = 4
) (
  input wire logic [6:0] fasErrMask,
  input wire logic nfasBitVal,
  input wire logic oofIn,
  output line_in_t lineOut
);
  logic lineClk = 1'b0;
  int bitIdx = 0;
  int frameIdx = 0;
  logic dataBit;
  logic [6:0] fasWord;
  // recovered clock runs free, data moves on the falling edge
  always #400 lineClk = ~lineClk;
  always @(negedge lineClk) begin
    if (bitIdx == FRAME_BITS - 1) begin
      bitIdx <= 0;
      frameIdx <= (frameIdx + 1) % 16;
    end else begin
      bitIdx <= bitIdx + 1;
    end
  end
  assign fasWord = `FAS_PATTERN ^ fasErrMask;
  always_comb begin
    // filler mixes ones and zeros outside timeslot 0
    dataBit = bitIdx[0] ^ bitIdx[2];
    if (frameIdx % 2 == 0 && bitIdx >= 1 && bitIdx <= 7) begin
      dataBit = fasWord[7 - bitIdx];
    end else if (frameIdx % 2 == 1 && bitIdx == 1) begin
      dataBit = nfasBitVal;
    end
  end
  assign lineOut = '{recoveredLineClock: lineClk, undecodedRxPcm: 1'b1, decodedRxPcm: dataBit,
    linePosPulse: 1'b0, lineNegPulse: 1'b1, slipBufferPcm: 1'b0, frameMark: bitIdx == 0,
    crcMfMark: bitIdx == 0 && frameIdx == 0, sigMfMark: bitIdx == 0 && frameIdx == SIG_OFS,
    outOfFrame: oofIn};
endmodule

//--- verif/e1_receive_options_ctrl_tb_top.sv
// testbench for the receive options register and receive-path selections
`timescale 1ns/1ns
module e1_receive_options_ctrl_tb_top;
  import e1_rx_pkg::*;
  localparam int FB = 32;
  localparam int MF = FB * 16 * 8;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic regSelect = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic backplaneDualRailSel = 1'b0;
  logic [7:0] slipBufferIdleCode = 8'hff;
  logic sigxCondActive = 1'b0;
  logic sigxCondData = 1'b0;
  logic backplaneSigIn = 1'b0;
  logic [6:0] fasErrMask = 7'h00;
  logic nfasBitVal = 1'b1;
  logic oofIn = 1'b0;
  line_in_t lineIn;
  logic [7:0] regRdData;
  logic rxPcm, rxFramePulse, backplaneRxPcm, backplaneNegRail, framingErrPulse;
  logic slipBypassRoute, slipSysClkFromTx;
  logic fpLast = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int errCnt = 0, fpRise = 0, fpRun = 0, fpWidth = 0, pcmLow = 0, bpLow = 0, negLow = 0;
  int expRise[4] = '{16, 1, 1, 1};
  int expWid[4] = '{8, 8, 8, (12 * FB + 1) * 8};
  int feOpt[4] = '{8'h00, 8'h80, 8'h40, 8'hc0};
  int feMask[4] = '{7'h07, 7'h07, 7'h00, 7'h07};
  int feNfas[4] = '{0, 1, 0, 0};
  int feExp[4] = '{24, 8, 8, 8};
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  e1_line_model #(.FRAME_BITS(FB), .SIG_OFS(4)) line_u (.fasErrMask(fasErrMask),
    .nfasBitVal(nfasBitVal), .oofIn(oofIn), .lineOut(lineIn));
  e1_receive_options_ctrl #(.FRAME_BITS(FB), .MF_FRAMES(16)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .regSelect(regSelect), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .recoveredLineClock(lineIn.recoveredLineClock), .undecodedRxPcm(lineIn.undecodedRxPcm),
    .decodedRxPcm(lineIn.decodedRxPcm), .linePosPulse(lineIn.linePosPulse),
    .lineNegPulse(lineIn.lineNegPulse), .slipBufferPcm(lineIn.slipBufferPcm),
    .frameMark(lineIn.frameMark), .crcMfMark(lineIn.crcMfMark), .sigMfMark(lineIn.sigMfMark),
    .outOfFrame(lineIn.outOfFrame), .backplaneDualRailSel(backplaneDualRailSel),
    .slipBufferIdleCode(slipBufferIdleCode), .sigxCondActive(sigxCondActive),
    .sigxCondData(sigxCondData), .backplaneSigIn(backplaneSigIn), .rxPcm(rxPcm),
    .rxFramePulse(rxFramePulse), .backplaneRxPcm(backplaneRxPcm),
    .backplaneNegRail(backplaneNegRail), .framingErrPulse(framingErrPulse),
    .slipBypassRoute(slipBypassRoute), .slipSysClkFromTx(slipSysClkFromTx));
  ////////////////////////////////////////////////////////////////////////////
  // free-running observers; scenarios take differences across a window
  always @(posedge sys_clk) begin
    errCnt <= errCnt + (framingErrPulse === 1'b1);
    pcmLow <= pcmLow + (rxPcm !== 1'b1);
    bpLow <= bpLow + (backplaneRxPcm !== 1'b1);
    negLow <= negLow + (backplaneNegRail !== 1'b1);
    fpLast <= rxFramePulse;
    if (rxFramePulse === 1'b1) begin
      fpRun <= fpRun + 1;
      if (fpLast !== 1'b1) fpRise <= fpRise + 1;
    end else if (fpLast === 1'b1) begin
      fpWidth <= fpRun;
      fpRun <= 0;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regSelect <= 1'b1;
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regSelect <= 1'b0;
    regWrite <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regSelect <= 1'b1;
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regSelect <= 1'b0;
    regRead <= 1'b0;
    @(posedge sys_clk);
    #1 d = regRdData;
  endtask
  // low-sample counts over one frame once the option has settled
  task automatic lows(output int dp, output int db, output int dn);
    int p0, b0, n0;
    wait_cyc(64);
    p0 = pcmLow;
    b0 = bpLow;
    n0 = negLow;
    wait_cyc(FB * 8);
    dp = pcmLow - p0;
    db = bpLow - b0;
    dn = negLow - n0;
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_cyc(90000);
    num_errors++;
    close_out;
  end
  initial begin
    logic [7:0] rd;
    int base, dp, db, dn;
    wait_cyc(3);
    rst <= 1'b0;
    reg_read(8'h00, rd);
    check("options after reset", rd, 8'h00);
    for (int i = 0; i < 8; i++) begin
      reg_write(8'h00, 8'h01 << i);
      reg_read(8'h00, rd);
      check("options walk", rd, 8'h01 << i);
    end
    reg_write(8'h00, 8'ha5);
    reg_write(8'h80, 8'h5a);
    reg_write(8'h01, 8'h5a);
    reg_read(8'h00, rd);
    check("options after foreign writes", rd, 8'ha5);
    // test page read must leave the last read value standing
    reg_read(8'h80, rd);
    check("test page read", rd, 8'ha5);
    reg_read(8'h01, rd);
    check("other normal address", rd, 8'h00);
    reg_write(8'h00, 8'h30);
    wait_cyc(64);
    check("bypass route", slipBypassRoute, 1'b1);
    check("slip clock source", slipSysClkFromTx, 1'b1);
    reg_write(8'h00, 8'h08);
    wait_cyc(64);
    check("bypass route off", slipBypassRoute, 1'b0);
    check("slip clock source off", slipSysClkFromTx, 1'b0);
    lows(dp, db, dn);
    check("raw pcm lows", dp, 0);
    reg_write(8'h00, 8'h00);
    lows(dp, db, dn);
    check("decoded pcm has lows", dp > 0, 1'b1);
    for (int m = 0; m < 4; m++) begin
      reg_write(8'h00, 8'(m << 1));
      wait_cyc(MF);
      base = fpRise;
      wait_cyc(MF);
      check("frame pulse count", fpRise - base, expRise[m]);
      check("frame pulse width", fpWidth, expWid[m]);
    end
    for (int k = 0; k < 4; k++) begin
      reg_write(8'h00, 8'(feOpt[k]));
      fasErrMask <= 7'(feMask[k]);
      nfasBitVal <= 1'(feNfas[k]);
      wait_cyc(FB * 16);
      base = errCnt;
      wait_cyc(MF);
      check("framing error count", errCnt - base, feExp[k]);
    end
    fasErrMask <= 7'h00;
    nfasBitVal <= 1'b1;
    reg_write(8'h00, 8'h01);
    oofIn <= 1'b1;
    lows(dp, db, dn);
    check("idle code insertion", db, 0);
    check("signalling on neg output", dn > 0, 1'b1);
    backplaneDualRailSel <= 1'b1;
    lows(dp, db, dn);
    check("dual rail pos output", db > 0, 1'b1);
    check("dual rail neg output", dn, 0);
    backplaneDualRailSel <= 1'b0;
    reg_write(8'h00, 8'h21);
    lows(dp, db, dn);
    check("bypass blocks conditioning", db > 0, 1'b1);
    reg_write(8'h00, 8'h00);
    sigxCondActive <= 1'b1;
    sigxCondData <= 1'b1;
    lows(dp, db, dn);
    check("per-timeslot conditioning", db, 0);
    ce <= 1'b0;
    reg_write(8'h00, 8'hff);
    ce <= 1'b1;
    reg_read(8'h00, rd);
    check("write while frozen", rd, 8'h00);
    close_out;
  end
endmodule
